// >>> design/area_wait_select.sv
`timescale 1ns/1ps
`include "area_wait_regs.svh"

// Function
// [RL1] Upper byte bits 14:12 hold area 7 wait count, read/write.
// [RL2] Upper byte bits 10:8 hold area 6 wait count, read/write.
// [RL3] Lower byte bits 6:4 hold area 5 wait count, read/write.
// [RL4] Field 000 inserts no wait; value n inserts exactly n waits.
// [RL5] Reserved bits 15, 11 and 7 read zero, writes ignored.
// [RL6] All three wait fields reset to all ones.
// [RL7] Access-state bit zero means two-state access with no waits.
// [RL8] Access start loads the wait field into a down-counter per state.
module area_wait_select
(
   input  wire logic                    ref_clk,   // System clock 20 MHz
   input  wire logic                    rst,       // Sync reset, high
   input  wire logic                    ce,        // Clock enable
   input  wire area_wait_pkg::reg_addr_t reg_addr,  // Register address
   input  wire area_wait_pkg::reg_byte_t reg_wdata, // Register write data
   input  wire logic                    reg_wr,    // Write strobe
   input  wire logic                    reg_rd,    // Read strobe
   output      area_wait_pkg::reg_byte_t reg_rdata, // Read data, next cycle
   input  wire logic                    acc_start, // Access start pulse
   input  wire area_wait_pkg::area_t     acc_area,  // Area of the access
   output      logic                    acc_wait,  // Insert wait state
   output      logic                    acc_busy,  // Sequencer not idle
   output      area_wait_pkg::wait_cnt_t wait_left, // Waits still to go
   output      area_wait_pkg::wait_cnt_t eff_wait7, // Area 7 waits in use
   output      area_wait_pkg::wait_cnt_t eff_wait6, // Area 6 waits in use
   output      area_wait_pkg::wait_cnt_t eff_wait5  // Area 5 waits in use
);
   import area_wait_pkg::*;

   // -------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------

   // Waits actually inserted for one area
   function automatic wait_cnt_t eff_wait
   (
      input logic      three_state,
      input wait_cnt_t field
   );
      eff_wait = three_state ? field : `WS_NO_WAIT; // RL4 RL7
   endfunction : eff_wait

   // Write strobe aimed at one register
   function automatic logic hit
   (
      input logic      strobe,
      input reg_addr_t addr,
      input reg_addr_t target
   );
      hit = strobe && (addr == target);
   endfunction : hit

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   wait_cnt_t  area_seven_wait;
   wait_cnt_t  area_six_wait;
   wait_cnt_t  area_five_wait;
   logic       area_seven_three_state_enable;
   logic       area_six_three_state_enable;
   logic       area_five_three_state_enable;
   logic       next_area_seven_three_state_enable;
   logic       next_area_six_three_state_enable;
   logic       next_area_five_three_state_enable;
   logic       wr_upper;
   logic       wr_lower;
   logic       wr_ast;
   reg_byte_t  next_rdata;
   reg_byte_t  wait_ctrl_upper_byte;
   reg_byte_t  wait_ctrl_lower_byte;
   reg_byte_t  access_state_ctrl_reg;
   reg_byte_t  status_byte;
   seq_state_e state;
   seq_state_e next_state;
   area_t      cur_area;
   area_t      next_cur_area;
   logic       cur_own;
   logic       next_cur_own;
   wait_cnt_t  start_wait;
   logic       area_known;
   logic       cnt_load;
   logic       cnt_dec;
   logic       cnt_last;
   wait_cnt_t  cnt_value;
   wait_cnt_t  next_eff7;
   wait_cnt_t  next_eff6;
   wait_cnt_t  next_eff5;

   // -------------------------------------------------------------
   // Register write decode
   // -------------------------------------------------------------
   assign wr_upper = hit(reg_wr, reg_addr, `WS_OFF_UPPER);
   assign wr_lower = hit(reg_wr, reg_addr, `WS_OFF_LOWER);
   assign wr_ast   = hit(reg_wr, reg_addr, `WS_OFF_AST);

   // -------------------------------------------------------------
   // Wait fields
   // -------------------------------------------------------------
   wait_field_reg u_area_seven
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr_en   (wr_upper),
      .wr_val  (reg_wdata[`WS_A7_HI:`WS_A7_LO]), // RL1
      .field   (area_seven_wait)
   );

   wait_field_reg u_area_six
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr_en   (wr_upper),
      .wr_val  (reg_wdata[`WS_A6_HI:`WS_A6_LO]), // RL2
      .field   (area_six_wait)
   );

   wait_field_reg u_area_five
   (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ce      (ce),
      .wr_en   (wr_lower),
      .wr_val  (reg_wdata[`WS_A5_HI:`WS_A5_LO]), // RL3
      .field   (area_five_wait)
   );

   // -------------------------------------------------------------
   // Access-state control bits
   // -------------------------------------------------------------
   always_comb
   begin
      next_area_seven_three_state_enable = area_seven_three_state_enable;
      next_area_six_three_state_enable = area_six_three_state_enable;
      next_area_five_three_state_enable = area_five_three_state_enable;
      if (wr_ast)
      begin
         next_area_seven_three_state_enable = reg_wdata[`WS_AREA_SEVEN_THREE_STATE_ENABLE_BIT];
         next_area_six_three_state_enable = reg_wdata[`WS_AREA_SIX_THREE_STATE_ENABLE_BIT];
         next_area_five_three_state_enable = reg_wdata[`WS_AREA_FIVE_THREE_STATE_ENABLE_BIT];
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         area_seven_three_state_enable <= `WS_AST_RST;
         area_six_three_state_enable   <= `WS_AST_RST;
         area_five_three_state_enable  <= `WS_AST_RST;
      end
      else if (ce)
      begin
         area_seven_three_state_enable <= next_area_seven_three_state_enable;
         area_six_three_state_enable   <= next_area_six_three_state_enable;
         area_five_three_state_enable  <= next_area_five_three_state_enable;
      end
   end

   // -------------------------------------------------------------
   // Read-back images, reserved bits forced to zero
   // -------------------------------------------------------------
   always_comb
   begin
      wait_ctrl_upper_byte = `WS_BYTE_ZERO; // RL5
      wait_ctrl_upper_byte[`WS_A7_HI:`WS_A7_LO] = area_seven_wait; // RL1
      wait_ctrl_upper_byte[`WS_A6_HI:`WS_A6_LO] = area_six_wait; // RL2
      wait_ctrl_lower_byte = `WS_BYTE_ZERO; // RL5
      wait_ctrl_lower_byte[`WS_A5_HI:`WS_A5_LO] = area_five_wait; // RL3
      access_state_ctrl_reg = `WS_BYTE_ZERO;
      access_state_ctrl_reg[`WS_AREA_SEVEN_THREE_STATE_ENABLE_BIT] = area_seven_three_state_enable;
      access_state_ctrl_reg[`WS_AREA_SIX_THREE_STATE_ENABLE_BIT] = area_six_three_state_enable;
      access_state_ctrl_reg[`WS_AREA_FIVE_THREE_STATE_ENABLE_BIT] = area_five_three_state_enable;
      status_byte = `WS_BYTE_ZERO;
      status_byte[`WS_ST_BUSY_BIT] = acc_busy;
      status_byte[`WS_ST_AREA_HI:`WS_ST_AREA_LO] = cur_area;
      status_byte[`WS_ST_OWN_BIT] = cur_own;
      status_byte[`WS_ST_LEFT_HI:`WS_ST_LEFT_LO] = cnt_value;
   end

   // -------------------------------------------------------------
   // Read port: data valid only in the cycle after the strobe
   // -------------------------------------------------------------
   always_comb
   begin
      next_rdata = `WS_BYTE_ZERO;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `WS_OFF_UPPER:  next_rdata = wait_ctrl_upper_byte;
            `WS_OFF_LOWER:  next_rdata = wait_ctrl_lower_byte;
            `WS_OFF_AST:    next_rdata = access_state_ctrl_reg;
            `WS_OFF_STATUS: next_rdata = status_byte;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         reg_rdata <= `WS_BYTE_ZERO;
      end
      else if (ce)
      begin
         reg_rdata <= next_rdata;
      end
   end

   // -------------------------------------------------------------
   // Effective wait counts per area
   // -------------------------------------------------------------
   always_comb
   begin
      next_eff7 = eff_wait(area_seven_three_state_enable, area_seven_wait);
      next_eff6 = eff_wait(area_six_three_state_enable, area_six_wait);
      next_eff5 = eff_wait(area_five_three_state_enable, area_five_wait);
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         eff_wait7 <= `WS_FIELD_RST;
         eff_wait6 <= `WS_FIELD_RST;
         eff_wait5 <= `WS_FIELD_RST;
      end
      else if (ce)
      begin
         eff_wait7 <= next_eff7;
         eff_wait6 <= next_eff6;
         eff_wait5 <= next_eff5;
      end
   end

   // -------------------------------------------------------------
   // Start value for the access just begun
   // -------------------------------------------------------------
   always_comb
   begin
      area_known = 1'b1;
      unique case (acc_area)
         `WS_AREA_SEVEN:
            start_wait = eff_wait(area_seven_three_state_enable,
                                  area_seven_wait); // RL4 RL7
         `WS_AREA_SIX:
            start_wait = eff_wait(area_six_three_state_enable,
                                  area_six_wait); // RL4 RL7
         `WS_AREA_FIVE:
            start_wait = eff_wait(area_five_three_state_enable,
                                  area_five_wait); // RL4 RL7
         default:
         begin
            // Areas 4 to 0 are timed elsewhere
            area_known = 1'b0;
            start_wait = `WS_NO_WAIT;
         end
      endcase
   end

   // -------------------------------------------------------------
   // Wait sequencer
   // -------------------------------------------------------------
   assign acc_busy  = (state == SEQ_WAIT);
   assign acc_wait  = (state == SEQ_WAIT); // RL8
   assign wait_left = cnt_value;
   assign cnt_load  = acc_start && (state == SEQ_IDLE);
   assign cnt_dec   = (state == SEQ_WAIT);

   wait_down_counter u_counter
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .ce       (ce),
      .load     (cnt_load),
      .load_val (start_wait),
      .dec      (cnt_dec),
      .count    (cnt_value),
      .last     (cnt_last)
   );

   always_comb
   begin
      next_state    = state;
      next_cur_area = cur_area;
      next_cur_own  = cur_own;
      unique case (state)
         SEQ_IDLE:
         begin
            if (acc_start)
            begin
               next_cur_area = acc_area;
               next_cur_own  = area_known;
               if (start_wait != `WS_NO_WAIT)
               begin
                  next_state = SEQ_WAIT; // RL8
               end
            end
         end
         SEQ_WAIT:
         begin
            // One bus state per count, leave when the last one ends
            if (cnt_last)
            begin
               next_state = SEQ_IDLE; // RL4 RL8
            end
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state    <= SEQ_IDLE;
         cur_area <= `WS_AREA_SEVEN;
         cur_own  <= 1'b0;
      end
      else if (ce)
      begin
         state    <= next_state;
         cur_area <= next_cur_area;
         cur_own  <= next_cur_own;
      end
   end

endmodule : area_wait_select

// >>> shared/area_wait_regs.svh
`ifndef AREA_WAIT_REGS_SVH
`define AREA_WAIT_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte-wide register port)
// ----------------------------------------------------------------
`define WS_OFF_UPPER     2'h0
`define WS_OFF_LOWER     2'h1
`define WS_OFF_AST       2'h2
`define WS_OFF_STATUS    2'h3

// ----------------------------------------------------------------
// Field positions inside each byte
// ----------------------------------------------------------------
`define WS_A7_HI         6
`define WS_A7_LO         4
`define WS_A6_HI         2
`define WS_A6_LO         0
`define WS_A5_HI         6
`define WS_A5_LO         4
`define WS_AREA_SEVEN_THREE_STATE_ENABLE_BIT      7
`define WS_AREA_SIX_THREE_STATE_ENABLE_BIT      6
`define WS_AREA_FIVE_THREE_STATE_ENABLE_BIT      5
`define WS_ST_BUSY_BIT   7
`define WS_ST_AREA_HI    6
`define WS_ST_AREA_LO    4
`define WS_ST_OWN_BIT    3
`define WS_ST_LEFT_HI    2
`define WS_ST_LEFT_LO    0

// ----------------------------------------------------------------
// Reset values and constants
// ----------------------------------------------------------------
`define WS_FIELD_RST     3'h7
`define WS_AST_RST       1'h1
`define WS_NO_WAIT       3'h0
`define WS_ONE           3'h1
`define WS_BYTE_ZERO     8'h00
`define WS_AREA_SEVEN    3'h7
`define WS_AREA_SIX      3'h6
`define WS_AREA_FIVE     3'h5

`endif

// >>> shared/area_wait_pkg.sv
package area_wait_pkg;

   typedef logic [2:0] wait_cnt_t;
   typedef logic [2:0] area_t;
   typedef logic [1:0] reg_addr_t;
   typedef logic [7:0] reg_byte_t;

   typedef enum logic {
      SEQ_IDLE,
      SEQ_WAIT
   } seq_state_e;

endpackage : area_wait_pkg

// >>> design/wait_field_reg.sv
`timescale 1ns/1ps
`include "area_wait_regs.svh"

// ----------------------------------------------------------------
// Three-bit wait field, all ones after reset
// ----------------------------------------------------------------
module wait_field_reg
(
   input  wire logic                   ref_clk, // System clock
   input  wire logic                   rst,     // Sync reset, high
   input  wire logic                   ce,      // Clock enable
   input  wire logic                   wr_en,   // Field write
   input  wire area_wait_pkg::wait_cnt_t wr_val, // Field write value
   output      area_wait_pkg::wait_cnt_t field   // Stored field
);
   import area_wait_pkg::*;

   wait_cnt_t next_field;

   always_comb
   begin
      next_field = field;
      if (wr_en)
      begin
         next_field = wr_val;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         field <= `WS_FIELD_RST; // RL6
      end
      else if (ce)
      begin
         field <= next_field;
      end
   end

endmodule : wait_field_reg

// >>> design/wait_down_counter.sv
`timescale 1ns/1ps
`include "area_wait_regs.svh"

// ----------------------------------------------------------------
// Loadable down-counter for inserted wait states
// ----------------------------------------------------------------
module wait_down_counter
(
   input  wire logic                   ref_clk, // System clock
   input  wire logic                   rst,     // Sync reset, high
   input  wire logic                   ce,      // Clock enable
   input  wire logic                   load,    // Load start value
   input  wire area_wait_pkg::wait_cnt_t load_val, // Start value
   input  wire logic                   dec,     // Count one state
   output      area_wait_pkg::wait_cnt_t count,  // Remaining states
   output      logic                   last     // One state left
);
   import area_wait_pkg::*;

   wait_cnt_t next_count;

   assign last = (count == `WS_ONE);

   always_comb
   begin
      next_count = count;
      if (load)
      begin
         next_count = load_val; // RL8
      end
      else if (dec && (count != `WS_NO_WAIT))
      begin
         next_count = count - `WS_ONE; // RL8
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         count <= `WS_NO_WAIT;
      end
      else if (ce)
      begin
         count <= next_count;
      end
   end

endmodule : wait_down_counter

// >>> bench/area_device_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External device: counts wait states it is given per access
// ----------------------------------------------------------------
module area_device_model
(
   input  wire logic       ref_clk,   // System clock
   input  wire logic       rst,       // Sync reset, high
   input  wire logic       acc_start, // Access start pulse
   input  wire logic       acc_wait,  // Wait state in progress
   output      logic [3:0] waits      // Waits seen this access
);
   import area_wait_pkg::*;

   logic [3:0] next_waits;

   // Starts during a wait do not open a new access
   always_comb
   begin
      next_waits = waits;
      if (acc_start && !acc_wait)
         next_waits = 4'h0;
      else if (acc_wait)
         next_waits = waits + 4'h1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         waits <= 4'h0;
      else
         waits <= next_waits;
   end
endmodule : area_device_model

// >>> bench/area_wait_select_monitor.sv
`timescale 1ns/1ps
`include "area_wait_regs.svh"

module area_wait_select_monitor
(
   input wire logic                     ref_clk,   // Clock
   input wire logic                     rst,       // Reset
   input wire logic                     ce,        // Clock enable
   input wire area_wait_pkg::reg_addr_t reg_addr,  // Address
   input wire area_wait_pkg::reg_byte_t reg_wdata, // Write data
   input wire logic                     reg_wr,    // Write strobe
   input wire logic                     reg_rd,    // Read strobe
   input wire area_wait_pkg::reg_byte_t reg_rdata, // Read data
   input wire logic                     acc_start, // Access start
   input wire area_wait_pkg::area_t     acc_area,  // Access area
   input wire logic                     acc_wait,  // Wait state
   input wire logic                     acc_busy,  // Busy
   input wire area_wait_pkg::wait_cnt_t wait_left, // Waits left
   input wire area_wait_pkg::wait_cnt_t eff_wait7, // Area 7 waits
   input wire area_wait_pkg::wait_cnt_t eff_wait6, // Area 6 waits
   input wire area_wait_pkg::wait_cnt_t eff_wait5  // Area 5 waits
);
   import area_wait_pkg::*;

   wait_cnt_t  sel_n;
   wait_cnt_t  exp_n;
   wait_cnt_t  next_exp_n;
   logic [3:0] run_cnt;
   logic [3:0] next_run_cnt;

   // ----------------------------------------------------------------
   // Expected wait count and length of the current wait run
   // ----------------------------------------------------------------
   always_comb
   begin
      case (acc_area)
         3'h7:    sel_n = eff_wait7;
         3'h6:    sel_n = eff_wait6;
         3'h5:    sel_n = eff_wait5;
         default: sel_n = 3'h0;
      endcase
      next_exp_n   = exp_n;
      next_run_cnt = run_cnt;
      if (ce && acc_start && !acc_busy)
      begin
         next_exp_n   = sel_n;
         next_run_cnt = 4'h0;
      end
      else if (ce && acc_wait)
         next_run_cnt = run_cnt + 4'h1;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         exp_n   <= 3'h0;
         run_cnt <= 4'h0;
      end
      else
      begin
         exp_n   <= next_exp_n;
         run_cnt <= next_run_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence s_take_wait;
      ce && acc_start && !acc_busy && sel_n != 3'h0;
   endsequence

   a_wait_begins: assert property (s_take_wait |=> acc_wait
      && wait_left == exp_n) else $error("wait did not start");
   a_wait_cap: assert property (acc_wait |-> run_cnt < {1'b0, exp_n})
      else $error("too many wait states");
   a_wait_full: assert property ($fell(acc_wait)
      |-> run_cnt == {1'b0, exp_n}) else $error("too few wait states");
   a_left_track: assert property (acc_wait
      |-> wait_left == exp_n - run_cnt[2:0]) else $error("bad count");
   a_left_idle: assert property (!acc_wait |-> wait_left == 3'h0)
      else $error("count not zero when idle");
   a_busy_wait: assert property ($rose(acc_busy) |-> $past(acc_start))
      else $error("wait began without a start");
   a_rdata_idle: assert property ($past(ce) && !$past(reg_rd)
      |-> reg_rdata == 8'h00) else $error("read data outside read");
   a_upper_resv: assert property ($past(reg_rd && reg_addr ==
      `WS_OFF_UPPER) |-> reg_rdata[7] == 1'b0 && reg_rdata[3] == 1'b0)
      else $error("upper reserved bit set");
   a_lower_resv: assert property ($past(reg_rd && reg_addr ==
      `WS_OFF_LOWER) |-> reg_rdata[7] == 1'b0 && reg_rdata[3:0] == 4'h0)
      else $error("lower reserved bit set");
   a_reset_eff: assert property ($past(rst) |-> eff_wait7 == 3'h7
      && eff_wait6 == 3'h7 && eff_wait5 == 3'h7)
      else $error("waits not maximal after reset");
   c_wait: cover property (s_take_wait);
endmodule : area_wait_select_monitor

bind area_wait_select area_wait_select_monitor i_area_wait_select_monitor
(
   .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .acc_start(acc_start), .acc_area(acc_area),
   .acc_wait(acc_wait), .acc_busy(acc_busy), .wait_left(wait_left),
   .eff_wait7(eff_wait7), .eff_wait6(eff_wait6), .eff_wait5(eff_wait5)
);

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "area_wait_regs.svh"

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
   $display("BAD %0t got %h exp %h", $time, g, e); end end

module tb;
   import area_wait_pkg::*;

   logic       ref_clk = 1'b0;
   logic       rst = 1'b1;
   logic       ce = 1'b1;
   reg_addr_t  reg_addr = 2'h0;
   reg_byte_t  reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   reg_byte_t  reg_rdata;
   logic       acc_start = 1'b0;
   area_t      acc_area = 3'h0;
   logic       acc_wait;
   logic       acc_busy;
   wait_cnt_t  wait_left;
   logic [3:0] waits;
   int         fails = 0;
   int         total_checks = 0;
   int         i;
   wait_cnt_t  n;
   reg_byte_t  d;
   logic [3:0] w;

   always #25 ref_clk = ~ref_clk;

   area_wait_select i_area_wait_select
   (
      .ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .acc_start(acc_start), .acc_area(acc_area),
      .acc_wait(acc_wait), .acc_busy(acc_busy), .wait_left(wait_left),
      .eff_wait7(), .eff_wait6(), .eff_wait5()
   );

   area_device_model i_area_device_model
   (
      .ref_clk(ref_clk), .rst(rst), .acc_start(acc_start),
      .acc_wait(acc_wait), .waits(waits)
   );

   // ----------------------------------------------------------------
   // Register port and access tasks
   // ----------------------------------------------------------------
   task wr(input reg_addr_t a, input reg_byte_t v);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task rd(input reg_addr_t a, output reg_byte_t v);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      @(negedge ref_clk);
      v = reg_rdata;
   endtask : rd

   // A second start during the wait run must be ignored
   task acc(input area_t a, input logic dbl, output logic [3:0] cnt);
      int k;
      @(posedge ref_clk);
      acc_start <= 1'b1;
      acc_area  <= a;
      @(posedge ref_clk);
      acc_start <= 1'b0;
      if (dbl)
      begin
         @(posedge ref_clk);
         acc_start <= 1'b1;
         @(posedge ref_clk);
         acc_start <= 1'b0;
      end
      k = 0;
      @(negedge ref_clk);
      while (acc_busy !== 1'b0 && k < 12)
      begin
         @(negedge ref_clk);
         k++;
      end
      if (k >= 12)
      begin
         fails++;
         $display("BAD %0t access did not end", $time);
      end
      cnt = waits;
   endtask : acc

   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up

   initial
   begin
      #2000000;
      fails++;
      wrap_up();
   end

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      rd(`WS_OFF_UPPER, d);
      `CHK(d, 8'h77)
      rd(`WS_OFF_LOWER, d);
      `CHK(d, 8'h70)
      rd(`WS_OFF_AST, d);
      `CHK(d, 8'he0)
      acc(3'h7, 1'b0, w);
      `CHK(w, 4'h7)
      wr(`WS_OFF_UPPER, 8'h88);
      rd(`WS_OFF_UPPER, d);
      `CHK(d, 8'h00)
      wr(`WS_OFF_LOWER, 8'h8f);
      rd(`WS_OFF_LOWER, d);
      `CHK(d, 8'h00)
      for (i = 0; i < 8; i++)
      begin
         n = wait_cnt_t'(i);
         wr(`WS_OFF_UPPER, {1'b1, n, 1'b1, ~n});
         wr(`WS_OFF_LOWER, {1'b1, n, 4'hf});
         rd(`WS_OFF_UPPER, d);
         `CHK(d, {1'b0, n, 1'b0, ~n})
         rd(`WS_OFF_LOWER, d);
         `CHK(d, {1'b0, n, 4'h0})
         acc(3'h7, 1'b0, w);
         `CHK(w, {1'b0, n})
         acc(3'h6, 1'b0, w);
         `CHK(w, {1'b0, ~n})
         acc(3'h5, 1'b0, w);
         `CHK(w, {1'b0, n})
      end
      rd(`WS_OFF_STATUS, d);
      `CHK(d, 8'h58)
      wr(`WS_OFF_STATUS, 8'hff);
      rd(`WS_OFF_STATUS, d);
      `CHK(d, 8'h58)
      acc(3'h3, 1'b0, w);
      `CHK(w, 4'h0)
      rd(`WS_OFF_STATUS, d);
      `CHK(d, 8'h30)
      wr(`WS_OFF_UPPER, 8'h77);
      wr(`WS_OFF_AST, 8'h00);
      rd(`WS_OFF_AST, d);
      `CHK(d, 8'h00)
      acc(3'h7, 1'b0, w);
      `CHK(w, 4'h0)
      wr(`WS_OFF_AST, 8'h40);
      acc(3'h6, 1'b0, w);
      `CHK(w, 4'h7)
      acc(3'h7, 1'b0, w);
      `CHK(w, 4'h0)
      acc(3'h5, 1'b0, w);
      `CHK(w, 4'h0)
      wr(`WS_OFF_AST, 8'hff);
      rd(`WS_OFF_AST, d);
      `CHK(d, 8'he0)
      // Mid-run reset brings every field back to its maximum
      wr(`WS_OFF_UPPER, 8'h00);
      wr(`WS_OFF_LOWER, 8'h00);
      @(posedge ref_clk);
      rst <= 1'b1;
      @(posedge ref_clk);
      rst <= 1'b0;
      rd(`WS_OFF_UPPER, d);
      `CHK(d, 8'h77)
      rd(`WS_OFF_LOWER, d);
      `CHK(d, 8'h70)
      // Clock enable low drops a write
      @(posedge ref_clk);
      ce <= 1'b0;
      wr(`WS_OFF_UPPER, 8'h00);
      ce <= 1'b1;
      rd(`WS_OFF_UPPER, d);
      `CHK(d, 8'h77)
      // Status seen in the middle of a wait run
      @(posedge ref_clk);
      acc_start <= 1'b1;
      acc_area  <= 3'h6;
      @(posedge ref_clk);
      acc_start <= 1'b0;
      rd(`WS_OFF_STATUS, d);
      `CHK(d, 8'hee)
      repeat (6) @(negedge ref_clk);
      `CHK(waits, 4'h7)
      acc(3'h7, 1'b1, w);
      `CHK(w, 4'h7)
      wrap_up();
   end
endmodule : tb
